/* File: rtob_pkg.sv */
// Purpose: Shared constants and carriers for the remote terminal option bits block
// Assumes: 32-bit Avalon-MM register bus, byte addresses, one word per register
// Notes:   Register map, field positions and reset values live here only
package rtob_pkg;

    // Register byte offsets
    localparam logic [3:0] CFG_OFS      = 4'h0;  // Option bits
    localparam logic [3:0] STAT_OFS     = 4'h4;  // Sticky event status, write one to clear
    localparam logic [3:0] MASK_OFS     = 4'h8;  // Interrupt mask, same layout as status
    localparam logic [3:0] STATE_OFS    = 4'hC;  // Read-only pointer and last id word

    // Option bit positions in the configuration word
    localparam int CFG_SUPPRESS_BIT     = 0;     // illegal_irq_suppress
    localparam int CFG_RESTRICT_BIT     = 1;     // pingpong_toggle_restrict
    localparam int CFG_UNUSED_BIT       = 2;     // Unused, reads zero
    localparam int CFG_SELECT_BIT       = 3;     // gap_or_broadcast_select
    localparam int CFG_W                = 4;     // Width of the option field
    localparam logic [CFG_W-1:0] CFG_RST = 4'h0; // Reset value of the options
    localparam logic [CFG_W-1:0] CFG_WMASK = 4'hB; // Writable option bits

    // Status and mask layout
    localparam int STAT_MSG_BIT         = 0;     // Enabled message interrupt
    localparam int STAT_TOGGLE_BIT      = 1;     // Pointer toggled
    localparam int STAT_MERR_BIT        = 2;     // Message ended in error
    localparam int STAT_W               = 3;     // Width of status and mask
    localparam logic [STAT_W-1:0] STAT_RST = 3'h0; // Reset value of status and mask

    // State word layout
    localparam int STATE_PTR_BIT        = 0;     // pingpong_buffer_pointer
    localparam int STATE_GOOD_BIT       = 1;     // Buffer with last good data
    localparam int STATE_ID_LSB         = 16;    // Last interrupt_id_word

    // interrupt_id_word layout
    localparam int IIW_W                = 16;    // Word width
    localparam int IIW_MERR_BIT         = 0;     // Message error
    localparam int IIW_ILL_BIT          = 1;     // Illegal message
    localparam int IIW_BCAST_BIT        = 2;     // Broadcast
    localparam int IIW_MSG_BIT          = 3;     // Message interrupt cause
    localparam int TTW_W                = 16;    // time_tag_word width

    localparam int DATA_W               = 32;    // Bus data width
    localparam int ADDR_W               = 4;     // Bus byte address width
    localparam int BE_W                 = 4;     // Byte enables

    // Result of one message from the protocol engine
    typedef struct packed {
        logic illegal;     // Command illegalized (incl. illegal word count)
        logic msg_error;   // Message ended in error
        logic busy;        // Answered with Busy status
        logic data_ok;     // Data transfer completed successfully
        logic broadcast;   // Broadcast command
        logic gap_error;   // Gap error seen
        logic pingpong;    // Subaddress uses ping-pong buffering
        logic irq_enabled; // Message interrupt enabled for this message
    } rtob_msg_t;

    // One interrupt log entry
    typedef struct packed {
        logic [IIW_W-1:0] id_word;   // interrupt_id_word
        logic [TTW_W-1:0] time_tag;  // time_tag_word
    } rtob_log_t;

endpackage

/* File: rtob_rst_sync.sv */
// Purpose: Release an asynchronous active-low reset in step with the clock
// Assumes: resetn may fall at any time
// Notes:   Assertion is immediate, release takes two clock edges
`timescale 1ns/1ps
`default_nettype none
module rtob_rst_sync (
    input  wire logic ref_clk,   // Block clock
    input  wire logic resetn,    // Raw reset, active low
    output var  logic rst_n      // Synchronised reset, active low
);
    logic meta_reg;              // First stage, read only by second stage

    // Two-stage release, constants only under reset
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            meta_reg <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            meta_reg <= 1'b1;
            rst_n    <= meta_reg;
        end
    end
endmodule
`default_nettype wire

/* File: rtob_top.sv */
// Purpose: Option bits shaping message result reporting of a remote terminal
// Assumes: Message engine gives one msg_end pulse per message with its result
// Notes:   Registers reached over Avalon-MM with waitrequest, one word each
// Functional notes
// RL1: Bit 13 gap error or broadcast, by select
// RL2: Unrestricted: no toggle on legal error messages
// RL3: Restricted: toggle only on successful transfers
// RL4: Inverted pointer marks last good buffer
// RL5: Suppress bit blocks irq for illegal messages
// RL6: Illegal word counts count as illegal too
// RL7: Log interrupts regardless of suppress bit
// RL8: Illegal message logs id, time; data untouched
// RL9: Id word shows broadcast, error, illegal
// RL10: Options reset zero, readable, unused bit zero
//
// The placing of the registers and the Avalon-MM slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module rtob_top (
    input  wire logic                       ref_clk,          // 10 MHz clock
    input  wire logic                       resetn,           // Async reset, active low
    input  wire logic [rtob_pkg::ADDR_W-1:0] avs_address,     // Byte address
    input  wire logic                       avs_read,         // Read request
    input  wire logic                       avs_write,        // Write request
    input  wire logic [rtob_pkg::BE_W-1:0]  avs_byteenable,   // Byte lanes
    input  wire logic [rtob_pkg::DATA_W-1:0] avs_writedata,   // Write data
    output var  logic [rtob_pkg::DATA_W-1:0] avs_readdata,    // Read data
    output var  logic                       avs_waitrequest,  // Stall
    input  wire logic                       msg_end,          // Message finished pulse
    input  wire rtob_pkg::rtob_msg_t        msg,              // Message result
    input  wire logic [rtob_pkg::TTW_W-1:0] time_tag,         // Current time tag
    output var  logic                       info_valid,       // Info bit 13 ready pulse
    output var  logic                       info_word_bit13_flag, // Bit 13 of info word
    output var  logic                       pingpong_toggle,  // Pointer toggled pulse
    output var  logic                       pingpong_buffer_pointer, // Active buffer
    output var  logic                       good_buffer,      // Last good data buffer
    output var  logic                       data_wr_en,       // Data words may update
    output var  logic                       log_wr,           // Log entry write pulse
    output var  rtob_pkg::rtob_log_t        log_entry,        // Log entry contents
    output var  logic                       irq_n             // Host interrupt, active low
);
    import rtob_pkg::*;

    logic                 rst_n;          // Synchronised reset
    logic [CFG_W-1:0]     cfg_reg;        // Option bits
    logic [STAT_W-1:0]    stat_reg;       // Sticky events
    logic [STAT_W-1:0]    stat_next;      // Next status
    logic [STAT_W-1:0]    mask_reg;       // Interrupt mask
    logic [STAT_W-1:0]    set_vec;        // Events of this message
    logic                 ptr_reg;        // Ping-pong pointer
    logic [IIW_W-1:0]     last_id_reg;    // Last logged id word
    logic                 wr_go;          // Write completes this edge
    logic                 rd_go;          // Read answer latched this edge
    logic                 do_toggle;      // Toggle decision
    logic                 irq_block;      // Illegal message with suppress set
    logic [IIW_W-1:0]     id_word;        // Id word for this message
    logic [DATA_W-1:0]    rd_mux;         // Read data selection
    logic [DATA_W-1:0]    cfg_merged;     // Option word after lane merge
    logic [DATA_W-1:0]    mask_merged;    // Mask word after lane merge

    // Reset release
    rtob_rst_sync u_rst_sync (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .rst_n   (rst_n)
    );

    // Toggle decision for one message, per restrict option
    function automatic logic toggle_decide(input logic limit_on, input rtob_msg_t m);
        logic t;
        t = 1'b0;
        if (!m.pingpong) begin
            t = 1'b0;                                              // No ping-pong buffer
        end else if (limit_on) begin
            t = m.data_ok && !m.msg_error && !m.illegal && !m.busy;  // RL3
        end else begin
            t = m.illegal || m.busy || !m.msg_error;               // RL2
        end
        return t;
    endfunction

    // Build the id word, same layout for every logged message
    function automatic logic [IIW_W-1:0] make_id(input rtob_msg_t m);
        logic [IIW_W-1:0] w;
        w = '0;
        w[IIW_BCAST_BIT] = m.broadcast;   // RL9
        w[IIW_MERR_BIT]  = m.msg_error;   // RL9
        w[IIW_ILL_BIT]   = m.illegal;     // RL9
        w[IIW_MSG_BIT]   = m.irq_enabled;
        return w;
    endfunction

    // Byte lane merge for a write
    function automatic logic [DATA_W-1:0] lane_merge(input logic [DATA_W-1:0] old,
                                                     input logic [DATA_W-1:0] nw,
                                                     input logic [BE_W-1:0]   be);
        logic [DATA_W-1:0] r;
        r = old;
        for (int i = 0; i < BE_W; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    assign do_toggle = msg_end && toggle_decide(cfg_reg[CFG_RESTRICT_BIT], msg);
    // Word count illegality arrives folded into msg.illegal, so it is caught here
    assign irq_block = cfg_reg[CFG_SUPPRESS_BIT] && msg.illegal;       // RL5 RL6
    assign id_word   = make_id(msg);
    assign wr_go     = avs_write && !avs_waitrequest;
    assign rd_go     = avs_read && avs_waitrequest;

    // Whole words merged per lane; each register keeps only its own field
    assign cfg_merged  = lane_merge({{(DATA_W-CFG_W){1'b0}}, cfg_reg}, avs_writedata,
                                    avs_byteenable);
    assign mask_merged = lane_merge({{(DATA_W-STAT_W){1'b0}}, mask_reg}, avs_writedata,
                                    avs_byteenable);

    // Bus handshake: one wait cycle, then the request completes
    // A fixed wait state keeps the read mux away from the completion edge
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_waitrequest <= 1'b1;
        end else if ((avs_read || avs_write) && avs_waitrequest) begin
            avs_waitrequest <= 1'b0;     // Answer next edge
        end else begin
            avs_waitrequest <= 1'b1;     // Idle or request just finished
        end
    end

    // Read data selection; unmapped addresses read zero
    always_comb begin
        rd_mux = '0;
        case (avs_address)
            CFG_OFS: begin
                rd_mux[CFG_W-1:0] = cfg_reg & CFG_WMASK;   // RL10
            end
            STAT_OFS: begin
                rd_mux[STAT_W-1:0] = stat_reg;
            end
            MASK_OFS: begin
                rd_mux[STAT_W-1:0] = mask_reg;
            end
            STATE_OFS: begin
                rd_mux[STATE_PTR_BIT]  = ptr_reg;
                rd_mux[STATE_GOOD_BIT] = ~ptr_reg;
                rd_mux[STATE_ID_LSB +: IIW_W] = last_id_reg;
            end
            default: begin
                rd_mux = '0;
            end
        endcase
    end

    // Read data latched in the wait cycle, stands through completion
    // Latching one edge before the take edge lets the address move right after completion
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata <= '0;
        end else if (rd_go) begin
            avs_readdata <= rd_mux;
        end
    end

    // Option bits; unused bit never stored
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_reg <= CFG_RST;                                         // RL10
        end else if (wr_go && avs_address == CFG_OFS) begin
            cfg_reg <= cfg_merged[CFG_W-1:0] & CFG_WMASK;              // RL10
        end
    end

    // Mask register
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_reg <= STAT_RST;
        end else if (wr_go && avs_address == MASK_OFS) begin
            mask_reg <= mask_merged[STAT_W-1:0];
        end
    end

    // Events of the current message; suppressed illegal ones raise nothing
    // Word count illegality is already part of msg.illegal
    always_comb begin
        set_vec = '0;
        if (msg_end && !irq_block) begin                               // RL5
            set_vec[STAT_MSG_BIT]    = msg.irq_enabled;
            set_vec[STAT_TOGGLE_BIT] = do_toggle;
            set_vec[STAT_MERR_BIT]   = msg.msg_error;
        end
    end

    // Status: write one clears, a new event in the same cycle wins
    // Clear looks at lane 0 only; the status field fits in one byte
    always_comb begin
        stat_next = stat_reg;
        if (wr_go && avs_address == STAT_OFS && avs_byteenable[0]) begin
            stat_next = stat_reg & ~avs_writedata[STAT_W-1:0];
        end
        stat_next = stat_next | set_vec;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            stat_reg <= STAT_RST;
        end else begin
            stat_reg <= stat_next;
        end
    end

    // Interrupt pin, low while an unmasked status bit is set
    // One cycle behind status, the price of a pin straight from a flop
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_n <= 1'b1;
        end else begin
            irq_n <= ~|(stat_reg & mask_reg);                          // RL5
        end
    end

    // Info word bit 13 chosen per message
    // Flag keeps its value between messages
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            info_valid           <= 1'b0;
            info_word_bit13_flag <= 1'b0;
        end else begin
            info_valid <= msg_end;
            if (msg_end) begin
                info_word_bit13_flag <= cfg_reg[CFG_SELECT_BIT] ? msg.broadcast
                                                                : msg.gap_error;  // RL1
            end
        end
    end

    // Ping-pong pointer; outputs kept complementary
    // good_buffer takes the old pointer, the buffer just filled
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ptr_reg                 <= 1'b0;
            pingpong_toggle         <= 1'b0;
            pingpong_buffer_pointer <= 1'b0;
            good_buffer             <= 1'b1;
        end else begin
            pingpong_toggle <= do_toggle;                              // RL2 RL3
            if (do_toggle) begin
                ptr_reg                 <= ~ptr_reg;
                pingpong_buffer_pointer <= ~ptr_reg;
                good_buffer             <= ptr_reg;                    // RL4
            end
        end
    end

    // Interrupt log write, independent of the suppress bit
    // Only id and time tag are written, so software still sees illegal commands
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            log_wr      <= 1'b0;
            log_entry   <= '0;
            last_id_reg <= '0;
        end else begin
            log_wr <= msg_end && (msg.irq_enabled || msg.illegal);    // RL7 RL8
            if (msg_end && (msg.irq_enabled || msg.illegal)) begin
                log_entry.id_word  <= id_word;                         // RL8 RL9
                log_entry.time_tag <= time_tag;                        // RL8
                last_id_reg        <= id_word;
            end
        end
    end

    // Data words only updated for legal messages
    // Illegal messages leave the data buffer locations untouched
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            data_wr_en <= 1'b0;
        end else begin
            data_wr_en <= msg_end && !msg.illegal;                     // RL8
        end
    end

    // Checks on the logic above
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // Flag source follows the select bit seen with the message
    bit13_select_a: assert property (msg_end |=> info_valid &&  // RL1
        info_word_bit13_flag == ($past(cfg_reg[CFG_SELECT_BIT]) ? $past(msg.broadcast)
                                                               : $past(msg.gap_error)))
        else $error("bit 13 flag wrong source");

    // Unrestricted: a legal message ending in error keeps the pointer
    no_error_toggle_a: assert property (msg_end && !cfg_reg[CFG_RESTRICT_BIT] &&  // RL2
        msg.pingpong && msg.msg_error && !msg.illegal && !msg.busy
        |=> !pingpong_toggle && $stable(pingpong_buffer_pointer))
        else $error("toggle on legal error message");

    // Restricted: every toggle traces back to a good transfer
    restrict_toggle_a: assert property (pingpong_toggle && $past(cfg_reg[CFG_RESTRICT_BIT])  // RL3
        |-> $past(msg.data_ok) && !$past(msg.illegal) && !$past(msg.busy))
        else $error("restricted toggle without good transfer");

    // Unrestricted: illegal and busy messages still flip the pointer
    busy_toggle_a: assert property (msg_end && !cfg_reg[CFG_RESTRICT_BIT] &&  // RL2
        msg.pingpong && (msg.illegal || msg.busy)
        |=> pingpong_toggle && pingpong_buffer_pointer != $past(pingpong_buffer_pointer))
        else $error("no toggle on illegal or busy");

    // The two pointer outputs never agree
    good_buffer_a: assert property (good_buffer != pingpong_buffer_pointer)  // RL4
        else $error("good buffer not inverted pointer");

    // A suppressed message raises no status bit
    irq_suppress_a: assert property (msg_end && irq_block  // RL5
        |=> (stat_reg & ~$past(stat_reg)) == '0)
        else $error("suppressed message set status");

    // With nothing pending, a suppressed message leaves the pin high
    irq_pin_quiet_a: assert property ((msg_end && irq_block && stat_reg == '0)  // RL6
        ##1 !msg_end |=> irq_n)
        else $error("irq pin asserted for illegal message");

    // Enabled interrupts are logged with the sampled time tag
    log_kept_a: assert property (msg_end && msg.irq_enabled  // RL7
        |=> log_wr && log_entry.time_tag == $past(time_tag))
        else $error("interrupt not logged");

    // Illegal messages log but leave the data words alone
    data_hold_a: assert property (msg_end && msg.illegal  // RL8
        |=> log_wr && !data_wr_en)
        else $error("illegal message updated data");

    // Id word fields of an illegal message
    id_format_a: assert property (msg_end && msg.illegal |=>  // RL9
        log_entry.id_word[IIW_ILL_BIT] &&
        log_entry.id_word[IIW_BCAST_BIT] == $past(msg.broadcast) &&
        log_entry.id_word[IIW_MERR_BIT] == $past(msg.msg_error))
        else $error("id word fields wrong");

    // Unused and unmapped option bits read zero
    cfg_unused_a: assert property (avs_read && !avs_waitrequest && avs_address == CFG_OFS  // RL10
        |-> avs_readdata[CFG_UNUSED_BIT] == 1'b0 && avs_readdata[DATA_W-1:CFG_W] == '0)
        else $error("unused option bit reads one");

    // Pin follows pending unmasked status one cycle later
    irq_level_a: assert property ((|(stat_reg & mask_reg)) |=> !irq_n)  // RL5
        else $error("irq pin not following status");

endmodule
`default_nettype wire

/* File: rtob_bc_model.sv */
// Purpose: Behavioural bus controller that hands message results to the block
// Assumes: One message per call, msg_end one clock wide
// Notes:   Result fields are inverted between messages so stale values never help
`timescale 1ns/1ps
`default_nettype none
module rtob_bc_model (
    input  wire logic                       ref_clk,  // Block clock
    output var  logic                       msg_end,  // Message finished pulse
    output var  rtob_pkg::rtob_msg_t        msg,      // Message result
    output var  logic [rtob_pkg::TTW_W-1:0] time_tag  // Free running time tag
);
    import rtob_pkg::*;

    // Quiet outputs from time zero
    initial begin
        msg_end = 1'b0;
        msg = '0;
        time_tag = 16'h0000;
    end

    // Time tag runs on whether or not a message is in flight
    always @(posedge ref_clk) begin
        time_tag <= time_tag + 16'h0001;
    end

    // One finished message; tag returns the time tag the block sampled
    task automatic send(input rtob_msg_t m, output logic [TTW_W-1:0] tag);
        @(posedge ref_clk);
        msg_end <= 1'b1;
        msg <= m;
        @(posedge ref_clk);
        tag = time_tag;
        msg_end <= 1'b0;
        msg <= ~m;  // Fields are not valid outside the pulse
    endtask
endmodule
`default_nettype wire

/* File: rt_message_option_bits_tb_top.sv */
// Purpose: Self-checking bench for the option bits block
// Assumes: One wait cycle per bus access is not relied upon
// Notes:   Expected pointer is tracked here from the expected toggle given with each message
`timescale 1ns/1ps
`default_nettype none
module rt_message_option_bits_tb_top;
    import rtob_pkg::*;

    logic                ref_clk = 1'b0;          // 10 MHz clock
    logic                resetn = 1'b0;           // Reset, active low
    logic [ADDR_W-1:0]   avs_address = 4'h0;      // Bus address
    logic                avs_read = 1'b0;         // Read strobe
    logic                avs_write = 1'b0;        // Write strobe
    logic [DATA_W-1:0]   avs_writedata = 32'h0;   // Write data
    logic [DATA_W-1:0]   avs_readdata;            // Read data
    logic                avs_waitrequest;         // Stall
    logic                msg_end;                 // From the controller model
    rtob_msg_t           msg;                     // Message result
    logic [TTW_W-1:0]    time_tag;                // Time tag
    logic                info_valid, flag, tgl;   // Message outputs
    logic                ptr, good, data_wr_en;   // Pointer outputs
    logic                log_wr, irq_n;           // Log and interrupt
    rtob_log_t           log_entry;               // Log contents
    int                  n_errors = 0;            // Mismatches
    int                  n_tests = 0;             // Comparisons
    int                  cycles = 0;              // Timeout counter
    logic                exp_ptr = 1'b0;          // Expected pointer
    logic [31:0]         rd;                      // Last read word

    always #50 ref_clk = ~ref_clk;

    rtob_bc_model bc (.ref_clk(ref_clk), .msg_end(msg_end), .msg(msg), .time_tag(time_tag));

    rtob_top dut (
        .ref_clk(ref_clk), .resetn(resetn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(4'hF),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .msg_end(msg_end), .msg(msg),
        .time_tag(time_tag), .info_valid(info_valid), .info_word_bit13_flag(flag),
        .pingpong_toggle(tgl), .pingpong_buffer_pointer(ptr), .good_buffer(good),
        .data_wr_en(data_wr_en), .log_wr(log_wr), .log_entry(log_entry), .irq_n(irq_n)
    );

    // Single place where the run ends
    task automatic print_verdict();
        if (n_errors == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // A hang counts as a mismatch
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            print_verdict();
        end
    end

    task automatic check(input string name, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", name, e, g);
        end
    endtask

    // Avalon access: held until waitrequest is sampled low
    task automatic bus(input logic [3:0] a, input logic wr, input logic [31:0] d);
        @(posedge ref_clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    // Send one message and judge the pulses that follow it
    task automatic run_msg(input rtob_msg_t m, input logic t);
        logic [15:0] tag;
        bc.send(m, tag);
        #1;
        check("toggle", t, tgl);
        if (t) exp_ptr = !exp_ptr;
        check("pointer", exp_ptr, ptr);
        check("good_buffer", {!exp_ptr}, good);
        check("info_valid", 1, info_valid);
        check("data_wr_en", !m.illegal, data_wr_en);
        check("log_wr", m.illegal | m.irq_enabled, log_wr);
        if (m.illegal | m.irq_enabled) check("log_tag", tag, log_entry.time_tag);
    endtask

    // Reset values, read back, unused bit and refused places
    task automatic t_regs();
        bus(CFG_OFS, 0, 0);
        check("cfg_rst", 0, rd);
        bus(STATE_OFS, 0, 0);
        check("state_rst", 32'h00000002, rd);
        bus(CFG_OFS, 1, 32'hFFFFFFFF);
        bus(4'h2, 1, 32'hFFFFFFFF);
        bus(STATE_OFS, 1, 32'hFFFFFFFF);
        bus(4'h2, 0, 0);
        check("unmapped", 0, rd);
        bus(CFG_OFS, 0, 0);
        check("cfg_rw", 32'h0000000B, rd);
        bus(STATE_OFS, 0, 0);
        check("state_ro", 32'h00000002, rd);
        bus(CFG_OFS, 1, 0);
    endtask

    // Bit 13 source follows the select bit
    task automatic t_flag();
        for (int s = 0; s < 2; s++) begin
            bus(CFG_OFS, 1, s << CFG_SELECT_BIT);
            run_msg(8'h14, 0);
            check("flag_gap", !s, flag);
            run_msg(8'h18, 0);
            check("flag_bcast", s, flag);
        end
        bus(CFG_OFS, 1, 0);
    endtask

    // Pointer toggling for every result kind, unrestricted then restricted
    task automatic t_toggle();
        logic [7:0] m [5] = '{8'h42, 8'h82, 8'h22, 8'h12, 8'h10};
        logic [4:0] e [2] = '{5'b01110, 5'b00010};
        for (int r = 0; r < 2; r++) begin
            bus(CFG_OFS, 1, r << CFG_RESTRICT_BIT);
            for (int i = 0; i < 5; i++) run_msg(m[i], e[r][4-i]);
        end
        bus(STATE_OFS, 0, 0);
        check("state_ptr", {!exp_ptr, exp_ptr}, rd[1:0]);
        bus(STAT_OFS, 0, 0);
        check("stat_tgl", 32'h6, rd);
        bus(CFG_OFS, 1, 0);
    endtask

    // Suppression, logging, id word, masking and clearing
    task automatic t_irq();
        bus(STAT_OFS, 1, 32'h7);
        bus(MASK_OFS, 1, 32'h7);
        bus(CFG_OFS, 1, 32'h1);
        run_msg(8'hC9, 0);
        check("iiw", 16'h000F, log_entry.id_word);
        @(posedge ref_clk);
        #1;
        check("irq_supp", 1, irq_n);
        bus(STAT_OFS, 0, 0);
        check("stat_supp", 0, rd);
        bus(CFG_OFS, 1, 0);
        run_msg(8'hC9, 0);
        @(posedge ref_clk);
        #1;
        check("irq_on", 0, irq_n);
        bus(STAT_OFS, 0, 0);
        check("stat_set", 32'h5, rd);
        bus(STAT_OFS, 1, 32'h5);
        bus(STAT_OFS, 0, 0);
        check("irq_clr", 1, irq_n);
        bus(MASK_OFS, 1, 0);
        run_msg(8'h11, 0);
        @(posedge ref_clk);
        #1;
        check("irq_masked", 1, irq_n);
        bus(MASK_OFS, 1, 32'h1);
        bus(STAT_OFS, 0, 0);
        check("irq_unmask", 0, irq_n);
        bus(STAT_OFS, 1, 32'h1);
        bus(STAT_OFS, 0, 0);
        check("irq_end", 1, irq_n);
    endtask

    // Main sequence
    initial begin
        repeat (10) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge ref_clk);
        #1;
        check("irq_rst", 1, irq_n);
        t_regs();
        t_flag();
        t_toggle();
        t_irq();
        print_verdict();
    end
endmodule
`default_nettype wire
